// File: hdl/iso_port_consts.vh
// Constants for the isolated serial port direction and framing control block.
`ifndef ISO_PORT_CONSTS_VH
`define ISO_PORT_CONSTS_VH
// ==========================================
// Port decode bases and interrupt numbers
// ==========================================
`define PLAIN_PORT_BASE 32'h06000080
`define ISO_PORT_BASE 32'h06000100
`define PORT_SPAN_MASK 32'hffffff80
`define PLAIN_PORT_IRQ 2'd1
`define ISO_PORT_IRQ 2'd2
// ==========================================
// Modem control register field positions
// ==========================================
`define MODEM_DIR_BIT 1
`define MODEM_CTRL_RESET 8'h00
// ==========================================
// Framing characters
// ==========================================
`define CHR_CR 8'h0d
`define CHR_ACK 8'h41
// ==========================================
// Timing
// ==========================================
`define CLK_PERIOD_NS 5
`define TURN_TIMEOUT_US 1000
`define TURN_TIMEOUT_CYC ((`TURN_TIMEOUT_US * 1000) / `CLK_PERIOD_NS)
`endif

// File: hdl/iso_port_ctrl.v
// Direction control, port decode and example framing for the isolated serial port.
`include "iso_port_consts.vh"
`default_nettype none
// How it works
// - Direction bit 0 transmits, 1 receives.
// - Two-wire mode mutes receiver while transmitting.
// - Four-wire mode keeps receiver always on.
// - RS-232 transmitter always enabled, mirrors traffic.
// - Decode both UART bases, route their interrupts.
// - Node transmits only when addressed on four-wire; the code also replies on its round-robin turn, in either wire mode.
// - Message: CR, address, command, data, checksum, CR.
// - Reply: acknowledge, data, then CR.
// - Silent node yields line after timeout.
// - Inverted direction sense; transmitter off at power up.
// - One UART shared; one path active.
module iso_port_ctrl #(
    parameter TURN_TIMEOUT = `TURN_TIMEOUT_CYC,
    parameter [7:0] MY_ADDR = 8'h22,
    parameter [7:0] MY_SLOT = 8'h01,
    parameter [7:0] NODE_COUNT = 8'h04
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [31:0] i_cpu_addr,
    input wire i_cpu_sel,
    input wire i_plain_port_irq,
    input wire i_iso_port_irq,
    input wire [7:0] i_modem_control_register,
    input wire i_wire_mode_select,
    input wire i_receive_source_select,
    input wire i_uart_txd,
    input wire i_rs485_rxd,
    input wire i_rs232_rxd,
    input wire i_round_robin,
    input wire [7:0] i_rx_char,
    input wire i_rx_valid,
    input wire i_reply_start,
    input wire [7:0] i_reply_data,
    input wire i_reply_valid,
    output wire o_reply_ready,
    output reg [7:0] o_tx_char,
    output reg o_tx_valid,
    input wire i_tx_ready,
    output reg o_plain_port_cs,
    output reg o_iso_port_cs,
    output reg o_cpu_irq1,
    output reg o_cpu_irq2,
    output reg o_line_tx_oe_n,
    output reg o_line_rx_en,
    output reg o_rs232_tx_en,
    output reg o_rs485_txd,
    output reg o_rs232_txd,
    output reg o_uart_rxd,
    output reg o_addressed,
    output reg o_frame_done,
    output reg o_my_turn
);
    // ==========================================
    // Decode helper
    // ==========================================
    // True when the address falls in the window of the given port base.
    function hits;
        input [31:0] addr;
        input [31:0] base;
        begin
            hits = ((addr & `PORT_SPAN_MASK) == base);
        end
    endfunction

    // ==========================================
    // Framing state
    // ==========================================
    localparam [2:0] ST_IDLE = 3'd0; // Waiting for the opening CR.
    localparam [2:0] ST_ADDR = 3'd1; // Expecting the unit address.
    localparam [2:0] ST_CMD = 3'd2; // Expecting the command character.
    localparam [2:0] ST_BODY = 3'd3; // Data and checksum until the closing CR.
    localparam [2:0] ST_SKIP = 3'd4; // Frame for another node.

    localparam [1:0] RP_IDLE = 2'd0; // No reply running.
    localparam [1:0] RP_ACK = 2'd1; // Sending the acknowledge.
    localparam [1:0] RP_DATA = 2'd2; // Passing reply data.
    localparam [1:0] RP_CR = 2'd3; // Sending the closing CR.

    reg [2:0] rx_st_q; // Receive framing state.
    reg [2:0] rx_st_d;
    reg [1:0] rp_st_q; // Reply state.
    reg [1:0] rp_st_d;
    reg grant_q; // Reply permission after being addressed.
    reg grant_d;
    reg [7:0] turn_q; // Slot currently owning the line.
    reg [7:0] turn_d;
    reg [7:0] rp_char; // Character offered to the buffer.
    reg rp_valid;
    wire dir_bit; // Direction bit out of the modem control register.
    wire tx_active; // Transmitter driving the line.
    wire rx_on; // Line receiver enabled.
    wire fifo_ready;
    wire [7:0] buf_data;
    wire buf_valid;
    wire frame_end; // Closing CR seen.
    wire timeout;

    assign dir_bit = i_modem_control_register[`MODEM_DIR_BIT];
    assign tx_active = ~dir_bit;
    // Four-wire leaves the receiver on; two-wire mutes it while sending.
    assign rx_on = i_wire_mode_select | ~tx_active;
    assign frame_end = i_rx_valid && (i_rx_char == `CHR_CR) && (rx_st_q == ST_BODY || rx_st_q == ST_SKIP);

    // ==========================================
    // Port decode and interrupt routing
    // ==========================================
    // Chip selects and interrupts registered so outputs come from flip-flops.
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_plain_port_cs <= 1'b0;
            o_iso_port_cs <= 1'b0;
            o_cpu_irq1 <= 1'b0;
            o_cpu_irq2 <= 1'b0;
        end else begin
            o_plain_port_cs <= i_cpu_sel && hits(i_cpu_addr, `PLAIN_PORT_BASE);
            o_iso_port_cs <= i_cpu_sel && hits(i_cpu_addr, `ISO_PORT_BASE);
            o_cpu_irq1 <= i_plain_port_irq;
            o_cpu_irq2 <= i_iso_port_irq;
        end
    end

    // ==========================================
    // Line drivers and receive path
    // ==========================================
    // During reset the line transmitter is off (enable high); after it the enable follows the direction bit.
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            o_line_tx_oe_n <= 1'b1;
            o_line_rx_en <= 1'b1;
            o_rs232_tx_en <= 1'b1;
            o_rs485_txd <= 1'b1;
            o_rs232_txd <= 1'b1;
            o_uart_rxd <= 1'b1;
        end else begin
            o_line_tx_oe_n <= ~tx_active;
            o_line_rx_en <= rx_on;
            o_rs232_tx_en <= 1'b1;
            o_rs485_txd <= i_uart_txd;
            o_rs232_txd <= i_uart_txd;
            // One UART: its input is taken from one path only.
            if (i_receive_source_select) begin
                o_uart_rxd <= rx_on ? i_rs485_rxd : 1'b1;
            end else begin
                o_uart_rxd <= i_rs232_rxd;
            end
        end
    end

    // ==========================================
    // Receive framing
    // ==========================================
    // A CR resynchronises to the address field, except in the body or skip state, where it ends the frame and returns to idle.
    always @* begin
        rx_st_d = rx_st_q;
        grant_d = grant_q;
        // The reply's closing CR ends the permission; a new frame below in the same cycle wins.
        if (rp_st_q == RP_CR && fifo_ready) begin
            grant_d = 1'b0;
        end
        if (i_rx_valid) begin
            case (rx_st_q)
                ST_IDLE: begin
                    if (i_rx_char == `CHR_CR) begin
                        rx_st_d = ST_ADDR;
                    end
                end
                ST_ADDR: begin
                    if (i_rx_char == `CHR_CR) begin
                        rx_st_d = ST_ADDR;
                    end else if (i_rx_char == MY_ADDR) begin
                        rx_st_d = ST_CMD;
                    end else begin
                        rx_st_d = ST_SKIP;
                    end
                end
                ST_CMD: begin
                    rx_st_d = (i_rx_char == `CHR_CR) ? ST_ADDR : ST_BODY;
                end
                ST_BODY: begin
                    if (i_rx_char == `CHR_CR) begin
                        rx_st_d = ST_IDLE;
                        grant_d = 1'b1;
                    end
                end
                ST_SKIP: begin
                    if (i_rx_char == `CHR_CR) begin
                        rx_st_d = ST_IDLE;
                    end
                end
                default: begin
                    rx_st_d = ST_IDLE;
                end
            endcase
        end
    end

    // ==========================================
    // Reply generation
    // ==========================================
    // Acknowledge first, then user data, then the closing CR.
    always @* begin
        rp_st_d = rp_st_q;
        rp_char = `CHR_ACK;
        rp_valid = 1'b0;
        case (rp_st_q)
            RP_IDLE: begin
                if (i_reply_start && (grant_q || o_my_turn)) begin
                    rp_st_d = RP_ACK;
                end
            end
            RP_ACK: begin
                rp_char = `CHR_ACK;
                rp_valid = 1'b1;
                if (fifo_ready) begin
                    rp_st_d = RP_DATA;
                end
            end
            RP_DATA: begin
                rp_char = i_reply_data;
                rp_valid = i_reply_valid;
                if (!i_reply_valid) begin
                    rp_st_d = RP_CR;
                end
            end
            RP_CR: begin
                rp_char = `CHR_CR;
                rp_valid = 1'b1;
                if (fifo_ready) begin
                    rp_st_d = RP_IDLE;
                end
            end
            default: begin
                rp_st_d = RP_IDLE;
            end
        endcase
    end
    assign o_reply_ready = (rp_st_q == RP_DATA) && fifo_ready;

    // ==========================================
    // Round-robin turn tracking
    // ==========================================
    // Each closing CR or expired silence hands the line to the next slot.
    always @* begin
        turn_d = turn_q;
        if (i_round_robin && (frame_end || timeout)) begin
            turn_d = (turn_q + 8'h01 >= NODE_COUNT) ? 8'h00 : turn_q + 8'h01;
        end
    end

    // State registers.
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            rx_st_q <= ST_IDLE;
            rp_st_q <= RP_IDLE;
            grant_q <= 1'b0;
            turn_q <= 8'h00;
            o_addressed <= 1'b0;
            o_frame_done <= 1'b0;
            o_my_turn <= 1'b0;
            o_tx_char <= `CHR_CR;
            o_tx_valid <= 1'b0;
        end else begin
            rx_st_q <= rx_st_d;
            rp_st_q <= rp_st_d;
            grant_q <= grant_d;
            turn_q <= turn_d;
            o_addressed <= grant_d;
            o_frame_done <= frame_end;
            o_my_turn <= i_round_robin && (turn_d == MY_SLOT);
            if (!o_tx_valid || i_tx_ready) begin
                o_tx_valid <= buf_valid;
                // Only a held word is loaded, so the unreset slots never reach the pins.
                if (buf_valid) begin
                    o_tx_char <= buf_data;
                end
            end
        end
    end

    // ==========================================
    // Outgoing buffer and turn timer
    // ==========================================
    skid_buffer #(
        .WIDTH(8)
    ) u_buf (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_data(rp_char),
        .i_valid(rp_valid),
        .o_ready(fifo_ready),
        .o_data(buf_data),
        .o_valid(buf_valid),
        .i_ready(!o_tx_valid || i_tx_ready)
    );

    turn_timer #(
        .TIMEOUT(TURN_TIMEOUT)
    ) u_timer (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_restart(i_rx_valid || frame_end || !i_round_robin),
        .o_expired(timeout)
    );
endmodule
`default_nettype wire

// File: hdl/skid_buffer.v
// Two-entry buffer with valid and ready on both sides.
`default_nettype none
module skid_buffer #(
    parameter WIDTH = 8
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire [WIDTH-1:0] i_data,
    input wire i_valid,
    output wire o_ready,
    output wire [WIDTH-1:0] o_data,
    output wire o_valid,
    input wire i_ready
);
    // ==========================================
    // Storage
    // ==========================================
    reg [WIDTH-1:0] mem_q [0:1]; // Two word slots.
    reg wr_q; // Write slot index.
    reg rd_q; // Read slot index.
    reg [1:0] cnt_q; // Words held.
    wire push;
    wire pop;
    assign o_ready = (cnt_q != 2'd2);
    assign o_valid = (cnt_q != 2'd0);
    assign o_data = mem_q[rd_q];
    assign push = i_valid && o_ready;
    assign pop = o_valid && i_ready;
    // Pointer and count update; the stall of the drain side fills the buffer.
    always @(posedge i_clk) begin
        if (!i_rst_n) begin
            wr_q <= 1'b0;
            rd_q <= 1'b0;
            cnt_q <= 2'd0;
        end else begin
            if (push) begin
                wr_q <= ~wr_q;
            end
            if (pop) begin
                rd_q <= ~rd_q;
            end
            if (push && !pop) begin
                cnt_q <= cnt_q + 2'd1;
            end else if (pop && !push) begin
                cnt_q <= cnt_q - 2'd1;
            end
        end
    end
    // Data slots carry no reset; they are read only when valid.
    always @(posedge i_clk) begin
        if (push) begin
            mem_q[wr_q] <= i_data;
        end
    end
endmodule
`default_nettype wire

// File: hdl/turn_timer.v
// Round-robin turn timer: counts silence and signals when the line passes on.
`default_nettype none
module turn_timer #(
    parameter TIMEOUT = 200000
) (
    input wire i_clk,
    input wire i_rst_n,
    input wire i_restart,
    output reg o_expired
);
    // ==========================================
    // Silence counter
    // ==========================================
    reg [31:0] cnt_q; // Cycles of silence so far.
    // Counts up while quiet; each full span of silence gives one pulse and starts the next span.
    always @(posedge i_clk) begin
        if (!i_rst_n || i_restart) begin
            cnt_q <= 32'h00000000;
            o_expired <= 1'b0;
        end else if (cnt_q >= TIMEOUT - 1) begin
            cnt_q <= 32'h00000000; // A silent slot hands the line on once, not every cycle.
            o_expired <= 1'b1;
        end else begin
            cnt_q <= cnt_q + 32'h00000001;
            o_expired <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: test/iso_port_ctrl_assertions.sv
// Concurrent checks on the ports of the isolated port control block.
`include "iso_port_consts.vh"
`default_nettype none
module iso_port_rules_chk (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic [31:0] i_cpu_addr,
    input wire logic i_cpu_sel,
    input wire logic i_plain_port_irq,
    input wire logic i_iso_port_irq,
    input wire logic [7:0] i_modem_control_register,
    input wire logic i_wire_mode_select,
    input wire logic i_receive_source_select,
    input wire logic i_uart_txd,
    input wire logic i_tx_ready,
    input wire logic [7:0] o_tx_char,
    input wire logic o_tx_valid,
    input wire logic o_plain_port_cs,
    input wire logic o_iso_port_cs,
    input wire logic o_cpu_irq1,
    input wire logic o_cpu_irq2,
    input wire logic o_line_tx_oe_n,
    input wire logic o_line_rx_en,
    input wire logic o_rs232_tx_en,
    input wire logic o_rs485_txd,
    input wire logic o_rs232_txd,
    input wire logic o_uart_rxd,
    input wire logic o_addressed,
    input wire logic o_frame_done,
    input wire logic o_my_turn
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Clocking and sequences
    // ==========================================
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_n);
    // An outgoing character is offered but not taken.
    sequence s_stall;
        o_tx_valid && !i_tx_ready;
    endsequence
    // The offer stays up with the same character.
    sequence s_held;
        o_tx_valid && $stable(o_tx_char);
    endsequence
    // ==========================================
    // Assertions
    // ==========================================
    AST_DIR: assert property ($past(i_rst_n) |->
        o_line_tx_oe_n == $past(i_modem_control_register[`MODEM_DIR_BIT]))
        else $error("direction output wrong");
    AST_RX_EN: assert property ($past(i_rst_n) |->
        o_line_rx_en == $past(i_wire_mode_select | i_modem_control_register[`MODEM_DIR_BIT]))
        else $error("receiver enable wrong");
    AST_RXD_MUTE: assert property ($past(i_rst_n && i_receive_source_select &&
        !(i_wire_mode_select | i_modem_control_register[`MODEM_DIR_BIT])) |-> o_uart_rxd)
        else $error("muted rxd not idle");
    AST_MIRROR: assert property ($past(i_rst_n) |->
        o_rs485_txd == $past(i_uart_txd) && o_rs232_txd == o_rs485_txd && o_rs232_tx_en) else $error("mirror wrong");
    AST_DECODE: assert property ($past(i_rst_n) |->
        o_iso_port_cs == $past(i_cpu_sel && (i_cpu_addr & `PORT_SPAN_MASK) == `ISO_PORT_BASE) &&
        o_plain_port_cs == $past(i_cpu_sel && (i_cpu_addr & `PORT_SPAN_MASK) == `PLAIN_PORT_BASE))
        else $error("port select wrong");
    AST_IRQ: assert property ($past(i_rst_n) |->
        o_cpu_irq1 == $past(i_plain_port_irq) && o_cpu_irq2 == $past(i_iso_port_irq)) else $error("irq route wrong");
    AST_SPEAK: assert property ($rose(o_tx_valid) |->
        $past(o_addressed, 2) || $past(o_my_turn) || $past(o_my_turn, 2) || $past(o_my_turn, 3))
        else $error("spoke unaddressed");
    AST_HOLD: assert property (s_stall |=> s_held) else $error("offer dropped");
    AST_DONE: assert property (o_frame_done |=> !o_frame_done) else $error("frame pulse long");
endmodule
bind iso_port_ctrl iso_port_rules_chk chk_u (.*);
`default_nettype wire

// File: test/iso_port_ctrl_tb_top.sv
// Self-checking bench for the isolated port control block.
`include "iso_port_consts.vh"
`default_nettype none
module iso_port_ctrl_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================
    // Stimulus and observed signals
    // ==========================================
    logic i_clk = 1'b0;
    logic i_rst_n = 1'b0;
    logic [31:0] i_cpu_addr = 32'h0;
    logic i_cpu_sel = 1'b0, i_plain_port_irq = 1'b0, i_iso_port_irq = 1'b0;
    logic [7:0] i_modem_control_register = 8'h00;
    logic i_wire_mode_select = 1'b0, i_receive_source_select = 1'b0, i_uart_txd = 1'b1;
    logic i_rs485_rxd = 1'b1, i_rs232_rxd = 1'b1, i_round_robin = 1'b0;
    logic [7:0] i_rx_char, i_reply_data = 8'h00;
    logic i_rx_valid, i_reply_start = 1'b0, i_reply_valid = 1'b0, i_tx_ready;
    logic o_reply_ready, o_tx_valid, o_plain_port_cs, o_iso_port_cs, o_cpu_irq1, o_cpu_irq2;
    logic o_line_tx_oe_n, o_line_rx_en, o_rs232_tx_en, o_rs485_txd, o_rs232_txd, o_uart_rxd;
    logic o_addressed, o_frame_done, o_my_turn;
    logic [7:0] o_tx_char;
    int mismatches = 0;
    int n_tests = 0;
    int fd_cnt = 0; // Count of closing-CR pulses.
    int fd0, w;
    logic dir, rxen, rep_take = 1'b0;
    logic [31:0] bases[3] = '{`PLAIN_PORT_BASE, `ISO_PORT_BASE, 32'h06000180};
    logic [7:0] expq[6] = '{`CHR_ACK, 8'h32, 8'h2e, 8'h33, 8'h34, `CHR_CR}; // Expected reply stream.
    // Short turn timeout keeps the round-robin wait brief.
    iso_port_ctrl #(.TURN_TIMEOUT(20)) dut_u (.*);
    line_node pn_u (.i_clk(i_clk), .o_rx_char(i_rx_char), .o_rx_valid(i_rx_valid),
        .i_tx_char(o_tx_char), .i_tx_valid(o_tx_valid), .o_tx_ready(i_tx_ready));
    always #2.5 i_clk = ~i_clk;
    // Bookkeeping sampled at the clock edge, before the edge's updates land.
    always @(posedge i_clk) begin
        rep_take <= i_reply_valid && o_reply_ready;
        fd_cnt <= fd_cnt + int'(o_frame_done);
    end
    // ==========================================
    // Shared tasks
    // ==========================================
    task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        n_tests++;
        if (seen !== exp) begin
            mismatches++;
            $display("ERROR %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // One-cycle request to start a reply.
    task automatic pulse_start();
        @(negedge i_clk);
        i_reply_start = 1'b1;
        @(negedge i_clk);
        i_reply_start = 1'b0;
    endtask
    // Offers one reply word and holds it until an edge takes it.
    task automatic feed(input logic [7:0] d);
        i_reply_valid = 1'b1;
        i_reply_data = d;
        w = 0;
        do begin
            @(negedge i_clk);
            w++;
        end while (!rep_take && w < 200);
    endtask
    task automatic tally_and_finish();
        if (mismatches == 0 && n_tests > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    // Watchdog: the tests need about two hundred cycles; twenty thousand is a hang.
    initial begin
        #(20000 * 5);
        mismatches++;
        tally_and_finish();
    end
    // ==========================================
    // Main sequence
    // ==========================================
    initial begin
        void'($urandom(32'hfa6b));
        repeat (10) @(negedge i_clk);
        check("rst_oe_n", o_line_tx_oe_n, 1'b1);
        check("rst_232en", o_rs232_tx_en, 1'b1);
        check("rst_char", o_tx_char, `CHR_CR);
        i_rst_n = 1'b1;
        // Random direction, mode, decode and interrupt traffic against the model.
        for (int k = 0; k < 60; k++) begin
            i_modem_control_register = 8'($urandom());
            {i_wire_mode_select, i_receive_source_select, i_uart_txd, i_rs485_rxd, i_rs232_rxd} = 5'($urandom());
            {i_cpu_sel, i_plain_port_irq, i_iso_port_irq} = 3'($urandom());
            i_cpu_addr = bases[k % 3] | 32'($urandom_range(127));
            dir = i_modem_control_register[`MODEM_DIR_BIT];
            rxen = i_wire_mode_select | dir;
            @(negedge i_clk);
            check("oe_n", o_line_tx_oe_n, dir);
            check("rx_en", o_line_rx_en, rxen);
            check("232en", o_rs232_tx_en, 1'b1);
            check("txd485", o_rs485_txd, i_uart_txd);
            check("txd232", o_rs232_txd, i_uart_txd);
            check("rxd", o_uart_rxd, i_receive_source_select ? (rxen ? i_rs485_rxd : 1'b1) : i_rs232_rxd);
            check("cs2", o_plain_port_cs, i_cpu_sel && (i_cpu_addr & `PORT_SPAN_MASK) == `PLAIN_PORT_BASE);
            check("cs3", o_iso_port_cs, i_cpu_sel && (i_cpu_addr & `PORT_SPAN_MASK) == `ISO_PORT_BASE);
            check("irq1", o_cpu_irq1, i_plain_port_irq);
            check("irq2", o_cpu_irq2, i_iso_port_irq);
        end
        // Four-wire use with the direction bit held high keeps the receiver on.
        i_wire_mode_select = 1'b1;
        i_modem_control_register = 8'h02;
        @(negedge i_clk);
        check("rs422_rx_en", o_line_rx_en, 1'b1);
        // A frame for another node must not let this one speak.
        pn_u.stall_pct = 50;
        pn_u.send_frame(8'h23);
        pulse_start();
        repeat (12) @(negedge i_clk);
        check("unaddr", o_addressed, 1'b0);
        check("silent", 8'(pn_u.got_q.size()), 8'h00);
        // An addressed frame, then a reply drained through a stalling receiver.
        fd0 = fd_cnt;
        pn_u.send_frame(8'h22);
        repeat (2) @(negedge i_clk);
        check("addressed", o_addressed, 1'b1);
        check("frame_done", 8'(fd_cnt - fd0), 8'h01);
        {i_wire_mode_select, i_modem_control_register} = {1'b0, 8'h00}; // Two-wire, line driven for the reply.
        pulse_start();
        for (int j = 1; j < 5; j++) feed(expq[j]);
        i_reply_valid = 1'b0;
        for (w = 0; w < 400 && pn_u.got_q.size() < 6; w++) @(negedge i_clk);
        check("reply_len", 8'(pn_u.got_q.size()), 8'h06);
        foreach (expq[j]) check("reply", pn_u.got_q[j], expq[j]);
        check("tx_oe_n", o_line_tx_oe_n, 1'b0);
        check("tx_rx_off", o_line_rx_en, 1'b0);
        i_modem_control_register = 8'h02; // Back to receive once the last character has gone.
        repeat (3) @(negedge i_clk);
        check("released", o_addressed, 1'b0);
        check("rx_dir", o_line_tx_oe_n, 1'b1);
        check("rx_back", o_line_rx_en, 1'b1);
        // Round robin: the turn arrives, and passes on after silence.
        i_round_robin = 1'b1;
        for (w = 0; w < 300 && o_my_turn !== 1'b1; w++) @(negedge i_clk);
        check("turn", o_my_turn, 1'b1);
        for (w = 0; w < 300 && o_my_turn !== 1'b0; w++) @(negedge i_clk);
        check("yield", o_my_turn, 1'b0);
        check("turn_len", 8'(w), 8'h14);
        tally_and_finish();
    end
endmodule
`default_nettype wire

// File: test/line_node.sv
// Far-side network node: sends frames to the port and drains its replies.
`include "iso_port_consts.vh"
`default_nettype none
module line_node (
    input wire logic i_clk,
    output logic [7:0] o_rx_char,
    output logic o_rx_valid,
    input wire logic [7:0] i_tx_char,
    input wire logic i_tx_valid,
    output logic o_tx_ready
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] got_q[$]; // Characters taken from the port, in order.
    int stall_pct = 0; // Chance in percent of refusing a character.
    initial begin
        o_rx_char = 8'h00;
        o_rx_valid = 1'b0;
        o_tx_ready = 1'b0;
    end
    // Ready changes off the sampling edge; stalls fill the reply buffer.
    always @(negedge i_clk) begin
        o_tx_ready <= ($urandom_range(99) >= stall_pct);
    end
    // A character is taken on an edge where it is offered and ready.
    always @(posedge i_clk) begin
        if (i_tx_valid && o_tx_ready) begin
            got_q.push_back(i_tx_char);
        end
    end
    // One character for one cycle; afterwards the line shows changed data.
    task automatic send_char(input logic [7:0] c);
        @(negedge i_clk);
        o_rx_char = c;
        o_rx_valid = 1'b1;
        @(negedge i_clk);
        o_rx_valid = 1'b0;
        o_rx_char = ~c;
    endtask
    // Host frame: CR, address, command, data, checksum, CR.
    task automatic send_frame(input logic [7:0] addr);
        logic [7:0] f[6];
        f = '{`CHR_CR, addr, 8'h4d, 8'h31, 8'h42, `CHR_CR};
        foreach (f[j]) send_char(f[j]);
    endtask
endmodule
`default_nettype wire
